/* design/cantmc_pkg.sv */
// shared types and constants for the transceiver mode control block
package cantmc_pkg;

  // transceiver mode field, upper bit set means supply monitoring active
  typedef enum logic [1:0] {
    CANTMC_OFF    = 2'b00,
    CANTMC_WAKE   = 2'b01,
    CANTMC_RXONLY = 2'b10,
    CANTMC_NORMAL = 2'b11
  } cantmc_mode_t;

  typedef enum logic [2:0] {
    CANTMC_CHIP_NORMAL   = 3'h0,
    CANTMC_CHIP_STOP     = 3'h1,
    CANTMC_CHIP_SLEEP    = 3'h2,
    CANTMC_CHIP_RESTART  = 3'h3,
    CANTMC_CHIP_FAILSAFE = 3'h4
  } cantmc_chip_t;

  typedef enum logic [1:0] {
    CANTMC_TERM_NONE = 2'h0,
    CANTMC_TERM_HALF = 2'h1,
    CANTMC_TERM_GND  = 2'h2,
    CANTMC_TERM_2V5  = 2'h3
  } cantmc_term_t;

  // one bus sample: receiver level, high is recessive
  typedef struct packed {
    logic bus_rx;
  } cantmc_word_t;

  localparam cantmc_mode_t RESET_MODE = CANTMC_OFF;

  // times in ns, plain defaults that an integrator may override
  localparam int CLK_NS          = 40;
  localparam int EN_SETTLE_NS    = 2000;
  localparam int WAKE_MIN_NS     = 1000;
  localparam int WAKE_MAX_NS     = 4000;
  localparam int SILENCE_NS      = 8000;
  localparam int TX_TIMEOUT_NS   = 16000;
  localparam int CLAMP_NS        = 32000;

  // least times round up, longest times round down
  localparam int EN_SETTLE_CYC   = (EN_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_MIN_CYC    = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_MAX_CYC    = WAKE_MAX_NS / CLK_NS;
  localparam int SILENCE_CYC     = (SILENCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TX_TIMEOUT_CYC  = (TX_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLAMP_CYC       = (CLAMP_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W = 12;

endpackage

/* design/cantmc_skid.sv */
// two-entry buffer carrying receiver samples toward the receive output
`timescale 1ns/1ps
`default_nettype none
module cantmc_skid (
  input  wire logic                 i_mclk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_valid,
  output logic                      o_ready,
  input  wire cantmc_pkg::cantmc_word_t i_data,
  output logic                      o_valid,
  input  wire logic                 i_ready,
  output cantmc_pkg::cantmc_word_t  o_data
);

  typedef struct packed {
    cantmc_pkg::cantmc_word_t [1:0] mem;
    logic                           wp;
    logic                           rp;
    logic [1:0]                     cnt;
  } cantmc_skid_t;

  cantmc_skid_t st;
  cantmc_skid_t next_st;
  logic         push;
  logic         pop;

  assign o_ready = (st.cnt != 2'h2);
  assign o_valid = (st.cnt != 2'h0);
  assign o_data  = st.mem[st.rp];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = i_data;
      next_st.wp = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

/* design/cantmc_top.sv */
// transceiver mode control, wake detection and bus supervision
`timescale 1ns/1ps
`default_nettype none
module cantmc_top #(
  parameter int EN_SETTLE_CYC  = cantmc_pkg::EN_SETTLE_CYC,
  parameter int WAKE_MIN_CYC   = cantmc_pkg::WAKE_MIN_CYC,
  parameter int WAKE_MAX_CYC   = cantmc_pkg::WAKE_MAX_CYC,
  parameter int SILENCE_CYC    = cantmc_pkg::SILENCE_CYC,
  parameter int TX_TIMEOUT_CYC = cantmc_pkg::TX_TIMEOUT_CYC,
  parameter int CLAMP_CYC      = cantmc_pkg::CLAMP_CYC
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_resetn,
  input  wire cantmc_pkg::cantmc_chip_t i_chip_mode,
  input  wire logic                     i_mode_wr,
  input  wire cantmc_pkg::cantmc_mode_t i_mode_sel,
  input  wire logic                     i_tx_data_in,
  input  wire logic                     i_bus_rx,
  input  wire logic                     i_supply_uv,
  input  wire logic                     i_watchdog_on_bus_wake,
  input  wire logic                     i_watchdog_enabled,
  input  wire logic                     i_wake_status_clr,
  input  wire logic                     i_fault_clr,
  input  wire logic                     i_uv_clr,
  output cantmc_pkg::cantmc_mode_t      o_mode,
  output logic                          o_rx_data_out,
  output logic                          o_bus_drive_dom,
  output cantmc_pkg::cantmc_term_t      o_term,
  output logic                          o_interrupt_out_n,
  output logic                          o_wake_status_reg0,
  output logic                          o_fault_flag,
  output logic                          o_supply_undervolt_flag,
  output logic                          o_watchdog_enable_req,
  output logic                          o_restart_req
);

  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_DOM1 = 2'b01,
    WK_REC  = 2'b10,
    WK_DOM2 = 2'b11
  } cantmc_wk_t;

  typedef struct packed {
    cantmc_pkg::cantmc_mode_t mode;
    cantmc_pkg::cantmc_chip_t chip_prev;
    cantmc_wk_t               wk;
    logic [11:0]              wk_cnt;
    logic                     woken;
    logic [11:0]              en_cnt;
    logic                     en_done;
    logic                     tx_arm;
    logic [11:0]              txto_cnt;
    logic                     txto;
    logic [11:0]              clamp_cnt;
    logic [11:0]              sil_cnt;
    logic                     rx;
    logic                     drive;
    cantmc_pkg::cantmc_term_t term;
    logic                     irq_n;
    logic                     wake_stat;
    logic                     fault;
    logic                     uvf;
    logic                     wd_req;
    logic                     rst_req;
  } cantmc_state_t;

  cantmc_state_t            st;
  cantmc_state_t            next_st;
  logic                     buf_out_vld;
  cantmc_pkg::cantmc_word_t buf_out;
  cantmc_pkg::cantmc_word_t buf_in;
  function automatic logic [11:0] cnt_inc(input logic [11:0] c);
    cnt_inc = (c == 12'hfff) ? c : c + 12'h001;
  endfunction
  function automatic logic in_win(input logic [11:0] c, input int lo, input int hi);
    in_win = (int'(c) >= lo) && (int'(c) < hi);
  endfunction
  assign buf_in.bus_rx = i_bus_rx;
  // sample path to the receive output; always drained, so no word is lost
  cantmc_skid u_skid (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_valid  (1'b1),
    .o_ready  (),
    .i_data   (buf_in),
    .o_valid  (buf_out_vld),
    .i_ready  (1'b1),
    .o_data   (buf_out)
  );

  always_comb begin
    logic mode_ok;
    logic wake_evt;
    logic chg;
    logic dom_tx;
    logic dom_bus;
    mode_ok  = 1'b0;
    wake_evt = 1'b0;
    chg      = 1'b0;
    dom_tx   = !i_tx_data_in;
    dom_bus  = !i_bus_rx;
    next_st  = st;
    next_st.chip_prev = i_chip_mode;
    next_st.wd_req  = 1'b0;
    next_st.rst_req = 1'b0;
    // mode selection, permitted per chip mode
    if (i_chip_mode == cantmc_pkg::CANTMC_CHIP_FAILSAFE) begin
      if (st.mode != cantmc_pkg::CANTMC_WAKE) begin
        next_st.mode = cantmc_pkg::CANTMC_WAKE;
        chg = 1'b1;
      end
    end else if (i_mode_wr) begin
      case (i_mode_sel)
        cantmc_pkg::CANTMC_OFF:    mode_ok = 1'b1;
        cantmc_pkg::CANTMC_NORMAL:
          mode_ok = (i_chip_mode == cantmc_pkg::CANTMC_CHIP_NORMAL);
        cantmc_pkg::CANTMC_RXONLY:
          mode_ok = (i_chip_mode == cantmc_pkg::CANTMC_CHIP_NORMAL) ||
                    (i_chip_mode == cantmc_pkg::CANTMC_CHIP_STOP);
        cantmc_pkg::CANTMC_WAKE:
          mode_ok = (i_chip_mode != cantmc_pkg::CANTMC_CHIP_FAILSAFE);
        default:   mode_ok = 1'b0;
      endcase
      if (mode_ok && (i_mode_sel != st.mode)) begin
        next_st.mode = i_mode_sel;
        chg = 1'b1;
      end
    end
    // leaving or entering any mode clears the woken state; writing the current mode again does not
    if (chg) begin
      next_st.woken   = 1'b0;
      next_st.wk      = WK_IDLE;
      next_st.wk_cnt  = '0;
      next_st.sil_cnt = '0;
      next_st.en_cnt  = '0;
      next_st.en_done = 1'b0;
      next_st.tx_arm  = 1'b0;
    end
    if ((i_chip_mode != st.chip_prev) &&
        ((i_chip_mode == cantmc_pkg::CANTMC_CHIP_STOP) ||
         (i_chip_mode == cantmc_pkg::CANTMC_CHIP_SLEEP) ||
         (i_chip_mode == cantmc_pkg::CANTMC_CHIP_FAILSAFE))) begin
      next_st.woken = 1'b0;
      next_st.wk    = WK_IDLE;
    end
    // wake pattern detector, active only in wake capable and not woken
    if (!chg && st.mode == cantmc_pkg::CANTMC_WAKE && !st.woken) begin
      next_st.wk_cnt = cnt_inc(st.wk_cnt);
      case (st.wk)
        WK_IDLE: if (dom_bus) begin
          next_st.wk = WK_DOM1;
          next_st.wk_cnt = 12'h001;
        end
        WK_DOM1: if (!dom_bus) begin
          next_st.wk = in_win(st.wk_cnt, WAKE_MIN_CYC, WAKE_MAX_CYC) ? WK_REC : WK_IDLE;
          next_st.wk_cnt = 12'h001;
        end
        WK_REC: if (dom_bus) begin
          next_st.wk = in_win(st.wk_cnt, WAKE_MIN_CYC + 1, WAKE_MAX_CYC) ? WK_DOM2 : WK_DOM1;
          next_st.wk_cnt = 12'h001;
        end else if (int'(st.wk_cnt) >= WAKE_MAX_CYC) begin
          next_st.wk = WK_IDLE;
        end
        WK_DOM2: begin
          if (int'(st.wk_cnt) >= WAKE_MIN_CYC && int'(st.wk_cnt) < WAKE_MAX_CYC) begin
            wake_evt = 1'b1;
            next_st.wk = WK_IDLE;
          end else if (!dom_bus) begin
            next_st.wk = WK_REC;
            next_st.wk_cnt = 12'h001;
          end
        end
        default: next_st.wk = WK_IDLE;
      endcase
    end
    // wake reaction per chip mode; mode field keeps reading wake capable
    if (wake_evt) begin
      next_st.woken = 1'b1;
      next_st.wake_stat = 1'b1;
      case (i_chip_mode)
        cantmc_pkg::CANTMC_CHIP_NORMAL: next_st.irq_n = 1'b0;
        cantmc_pkg::CANTMC_CHIP_STOP: begin
          next_st.irq_n = 1'b0;
          next_st.wd_req = i_watchdog_on_bus_wake && !i_watchdog_enabled;
        end
        cantmc_pkg::CANTMC_CHIP_SLEEP,
        cantmc_pkg::CANTMC_CHIP_FAILSAFE: next_st.rst_req = 1'b1;
        default: next_st.rst_req = 1'b0;
      endcase
    end else if (i_wake_status_clr) begin
      next_st.wake_stat = 1'b0;
      next_st.irq_n = 1'b1;
    end
    // enable settle: dominant during or spanning the settle time is suppressed
    if (!chg && st.mode == cantmc_pkg::CANTMC_NORMAL) begin
      if (!st.en_done) begin
        next_st.en_cnt = cnt_inc(st.en_cnt);
        next_st.en_done = (int'(st.en_cnt) + 1 >= EN_SETTLE_CYC);
      end else if (!dom_tx) begin
        next_st.tx_arm = 1'b1;
      end
    end
    // transmit dominant time-out
    if (st.mode == cantmc_pkg::CANTMC_NORMAL && dom_tx) begin
      next_st.txto_cnt = cnt_inc(st.txto_cnt);
      if (int'(st.txto_cnt) + 1 > TX_TIMEOUT_CYC) begin
        next_st.txto = 1'b1;
      end
    end else begin
      next_st.txto_cnt = '0;
      next_st.txto = 1'b0;
    end
    // bus clamp detection
    if (st.mode[1] && dom_bus) begin
      next_st.clamp_cnt = cnt_inc(st.clamp_cnt);
    end else begin
      next_st.clamp_cnt = '0;
    end
    // fault flag: set wins over clear
    if ((st.mode == cantmc_pkg::CANTMC_NORMAL && dom_tx &&
         int'(st.txto_cnt) + 1 > TX_TIMEOUT_CYC) ||
        (st.mode[1] && dom_bus && int'(st.clamp_cnt) + 1 > CLAMP_CYC)) begin
      next_st.fault = 1'b1;
    end else if (i_fault_clr) begin
      next_st.fault = 1'b0;
    end
    // undervoltage flag, only watched with upper mode bit set
    if (st.mode[1] && i_supply_uv) begin
      next_st.uvf = 1'b1;
    end else if (i_uv_clr) begin
      next_st.uvf = 1'b0;
    end
    // driver: normal mode, armed, no time-out, no undervoltage
    next_st.drive = (next_st.mode == cantmc_pkg::CANTMC_NORMAL) && next_st.tx_arm &&
                    !next_st.txto && !(st.mode[1] && i_supply_uv) && dom_tx;
    // receive output
    if (st.mode == cantmc_pkg::CANTMC_WAKE && (st.woken || wake_evt) && !chg) begin
      next_st.rx = 1'b0;
    end else if (st.mode[1] && buf_out_vld) begin
      next_st.rx = buf_out.bus_rx;
    end else begin
      next_st.rx = 1'b1;
    end
    // termination and silence timer
    if (st.mode == cantmc_pkg::CANTMC_WAKE && !chg) begin
      next_st.sil_cnt = cnt_inc(st.sil_cnt);
    end
    case (next_st.mode)
      cantmc_pkg::CANTMC_NORMAL: next_st.term = cantmc_pkg::CANTMC_TERM_HALF;
      cantmc_pkg::CANTMC_RXONLY:
        next_st.term = i_supply_uv ? cantmc_pkg::CANTMC_TERM_2V5
                                   : cantmc_pkg::CANTMC_TERM_HALF;
      cantmc_pkg::CANTMC_WAKE:
        if (next_st.woken) next_st.term = cantmc_pkg::CANTMC_TERM_2V5;
        else if (int'(next_st.sil_cnt) >= SILENCE_CYC) next_st.term = cantmc_pkg::CANTMC_TERM_GND;
        else next_st.term = cantmc_pkg::CANTMC_TERM_NONE;
      default: next_st.term = cantmc_pkg::CANTMC_TERM_NONE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.mode  <= cantmc_pkg::RESET_MODE;
      st.rx    <= 1'b1;
      st.irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_mode                  = st.mode;
  assign o_rx_data_out           = st.rx;
  assign o_bus_drive_dom         = st.drive;
  assign o_term                  = st.term;
  assign o_interrupt_out_n       = st.irq_n;
  assign o_wake_status_reg0      = st.wake_stat;
  assign o_fault_flag            = st.fault;
  assign o_supply_undervolt_flag = st.uvf;
  assign o_watchdog_enable_req   = st.wd_req;
  assign o_restart_req           = st.rst_req;

  // assertions
  initial if (CLAMP_CYC <= TX_TIMEOUT_CYC) $error("clamp time not above time-out");
  property p_reset_off;
    @(posedge i_mclk) disable iff (!i_resetn)
    $rose(i_resetn) |-> o_mode == cantmc_pkg::CANTMC_OFF;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("mode not off after reset");
  property p_normal_only_chip_normal;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_mode != cantmc_pkg::CANTMC_NORMAL && $past(o_mode) != cantmc_pkg::CANTMC_NORMAL) ##1
    (o_mode == cantmc_pkg::CANTMC_NORMAL) |-> $past(i_chip_mode) == cantmc_pkg::CANTMC_CHIP_NORMAL;
  endproperty
  a_normal_only_chip_normal: assert property (p_normal_only_chip_normal) else $error("normal entered illegally");
  property p_no_drive_outside_normal;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_bus_drive_dom |-> o_mode == cantmc_pkg::CANTMC_NORMAL;
  endproperty
  a_no_drive_outside_normal: assert property (p_no_drive_outside_normal) else $error("driving outside normal");
  property p_failsafe_wake;
    @(posedge i_mclk) disable iff (!i_resetn)
    i_chip_mode == cantmc_pkg::CANTMC_CHIP_FAILSAFE |=> o_mode == cantmc_pkg::CANTMC_WAKE;
  endproperty
  a_failsafe_wake: assert property (p_failsafe_wake) else $error("fail-safe not wake capable");
  sequence s_wake_hit;
    $rose(o_wake_status_reg0) && o_mode == cantmc_pkg::CANTMC_WAKE;
  endsequence
  property p_wake_rx_low;
    @(posedge i_mclk) disable iff (!i_resetn)
    s_wake_hit |-> !o_rx_data_out ##1 (!o_rx_data_out || $past(i_mode_wr) || $past(i_chip_mode) == cantmc_pkg::CANTMC_CHIP_FAILSAFE || o_mode != cantmc_pkg::CANTMC_WAKE);
  endproperty
  a_wake_rx_low: assert property (p_wake_rx_low) else $error("receive output not low after wake");
  property p_stop_irq;
    @(posedge i_mclk) disable iff (!i_resetn)
    ($rose(o_wake_status_reg0) && $past(i_chip_mode) == cantmc_pkg::CANTMC_CHIP_STOP) |-> !o_interrupt_out_n;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("no interrupt for stop wake");
  property p_sleep_no_irq;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_restart_req |-> $stable(o_interrupt_out_n);
  endproperty
  a_sleep_no_irq: assert property (p_sleep_no_irq) else $error("interrupt on sleep wake");
  property p_txto_recessive;
    @(posedge i_mclk) disable iff (!i_resetn)
    st.txto |-> !o_bus_drive_dom ##1 (st.txto || !o_bus_drive_dom || $past(i_tx_data_in) == 1'b0);
  endproperty
  a_txto_recessive: assert property (p_txto_recessive) else $error("driving during time-out");
  property p_off_no_term;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_mode == cantmc_pkg::CANTMC_OFF |-> o_term == cantmc_pkg::CANTMC_TERM_NONE;
  endproperty
  a_off_no_term: assert property (p_off_no_term) else $error("termination in off");
  property p_uv_no_drive;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_mode[1] && i_supply_uv) |=> !o_bus_drive_dom && o_supply_undervolt_flag;
  endproperty
  a_uv_no_drive: assert property (p_uv_no_drive) else $error("undervoltage not handled");

endmodule
`default_nettype wire

/* test/cantmc_ctrl_model.sv */
// behavioural protocol controller driving the transmit input
`timescale 1ns/1ps
`default_nettype none
module cantmc_ctrl_model (
  input  wire logic i_mclk,
  output logic      o_tx_data_in
);
  initial o_tx_data_in = 1'b1;

  // level held for n cycles, low is dominant
  task automatic drive(input logic lvl, input int n);
    @(posedge i_mclk);
    o_tx_data_in <= lvl;
    repeat (n) @(posedge i_mclk);
  endtask

  // recessive while the transceiver settles after enabling
  task automatic enable_wait(input int n);
    drive(1'b1, n);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the transceiver mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SETTLE = 2;
  localparam int SIL    = 6;
  localparam int TXTO   = 20;
  localparam int CLAMP  = 40;

  logic                     i_mclk = 1'b0;
  logic                     i_resetn = 1'b0;
  cantmc_pkg::cantmc_chip_t i_chip_mode = cantmc_pkg::CANTMC_CHIP_NORMAL;
  logic                     i_mode_wr = 1'b0;
  cantmc_pkg::cantmc_mode_t i_mode_sel = cantmc_pkg::CANTMC_OFF;
  logic                     tx;
  logic                     i_bus_rx = 1'b1;
  logic                     i_supply_uv = 1'b0;
  logic                     i_clr = 1'b0;
  cantmc_pkg::cantmc_mode_t o_mode;
  cantmc_pkg::cantmc_term_t o_term;
  logic                     o_rx, o_dom, o_irq_n, o_wk, o_fault, o_uv, o_wd, o_rst;
  int                       n_wd = 0;
  logic                     wd_en = 1'b0;
  logic                     seen_rst = 1'b0;
  int                       num_errors = 0;
  int                       n_tests = 0;

  always #20 i_mclk = ~i_mclk;

  cantmc_ctrl_model u_ctrl (.i_mclk(i_mclk), .o_tx_data_in(tx));

  cantmc_top #(.EN_SETTLE_CYC(SETTLE), .WAKE_MIN_CYC(4), .WAKE_MAX_CYC(10),
    .SILENCE_CYC(SIL), .TX_TIMEOUT_CYC(TXTO), .CLAMP_CYC(CLAMP)) u_dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_chip_mode(i_chip_mode),
    .i_mode_wr(i_mode_wr), .i_mode_sel(i_mode_sel), .i_tx_data_in(tx),
    .i_bus_rx(i_bus_rx), .i_supply_uv(i_supply_uv), .i_watchdog_on_bus_wake(1'b1),
    .i_watchdog_enabled(wd_en), .i_wake_status_clr(i_clr), .i_fault_clr(i_clr),
    .i_uv_clr(i_clr), .o_mode(o_mode), .o_rx_data_out(o_rx), .o_bus_drive_dom(o_dom),
    .o_term(o_term), .o_interrupt_out_n(o_irq_n), .o_wake_status_reg0(o_wk),
    .o_fault_flag(o_fault), .o_supply_undervolt_flag(o_uv),
    .o_watchdog_enable_req(o_wd), .o_restart_req(o_rst));

  always @(posedge i_mclk) begin
    if (o_wd === 1'b1) n_wd <= n_wd + 1;
    if (o_rst === 1'b1) seen_rst <= 1'b1;
  end

  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    #1;
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic set_mode(input cantmc_pkg::cantmc_mode_t m);
    @(posedge i_mclk);
    i_mode_wr <= 1'b1;
    i_mode_sel <= m;
    @(posedge i_mclk);
    i_mode_wr <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic chip(input cantmc_pkg::cantmc_chip_t c);
    @(posedge i_mclk);
    i_chip_mode <= c;
    repeat (2) @(posedge i_mclk);
  endtask

  task automatic bus(input logic lvl, input int n);
    @(posedge i_mclk);
    i_bus_rx <= lvl;
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic uv(input logic lvl);
    @(posedge i_mclk);
    i_supply_uv <= lvl;
    repeat (3) @(posedge i_mclk);
  endtask

  task automatic clr_flags();
    @(posedge i_mclk);
    i_clr <= 1'b1;
    @(posedge i_mclk);
    i_clr <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic wake_pat();
    bus(1'b0, 6);
    bus(1'b1, 6);
    bus(1'b0, 6);
    bus(1'b1, 4);
  endtask

  task automatic t_reset();
    chk("mode", cantmc_pkg::CANTMC_OFF, o_mode);
    chk("rx", 1, o_rx);
    chk("irq_n", 1, o_irq_n);
    chk("term", cantmc_pkg::CANTMC_TERM_NONE, o_term);
  endtask

  task automatic t_normal();
    chip(cantmc_pkg::CANTMC_CHIP_STOP);
    set_mode(cantmc_pkg::CANTMC_NORMAL);
    chk("mode", cantmc_pkg::CANTMC_OFF, o_mode);
    chip(cantmc_pkg::CANTMC_CHIP_NORMAL);
    u_ctrl.drive(1'b0, 1);
    set_mode(cantmc_pkg::CANTMC_NORMAL);
    chk("mode", cantmc_pkg::CANTMC_NORMAL, o_mode);
    chk("term", cantmc_pkg::CANTMC_TERM_HALF, o_term);
    u_ctrl.drive(1'b0, SETTLE + 3);
    chk("drive", 0, o_dom);
    u_ctrl.enable_wait(SETTLE);
    u_ctrl.drive(1'b0, 3);
    chk("drive", 1, o_dom);
    u_ctrl.drive(1'b1, 3);
    chk("drive", 0, o_dom);
    bus(1'b0, 3);
    chk("rx", 0, o_rx);
    bus(1'b1, 3);
    chk("rx", 1, o_rx);
  endtask

  task automatic t_timeout();
    u_ctrl.drive(1'b0, TXTO + 5);
    chk("drive", 0, o_dom);
    chk("fault", 1, o_fault);
    chk("mode", cantmc_pkg::CANTMC_NORMAL, o_mode);
    u_ctrl.drive(1'b1, 2);
    u_ctrl.drive(1'b0, 3);
    chk("drive", 1, o_dom);
    u_ctrl.drive(1'b1, 2);
    clr_flags();
    chk("fault", 0, o_fault);
  endtask

  task automatic t_rxonly();
    set_mode(cantmc_pkg::CANTMC_RXONLY);
    u_ctrl.drive(1'b0, 3);
    chk("drive", 0, o_dom);
    u_ctrl.drive(1'b1, 1);
    bus(1'b0, CLAMP + 5);
    chk("fault", 1, o_fault);
    chk("mode", cantmc_pkg::CANTMC_RXONLY, o_mode);
    bus(1'b1, 3);
    uv(1'b1);
    chk("uv", 1, o_uv);
    chk("term", cantmc_pkg::CANTMC_TERM_2V5, o_term);
    set_mode(cantmc_pkg::CANTMC_NORMAL);
    u_ctrl.enable_wait(SETTLE);
    u_ctrl.drive(1'b0, 3);
    chk("drive", 0, o_dom);
    u_ctrl.drive(1'b1, 1);
    uv(1'b0);
    u_ctrl.drive(1'b0, 3);
    chk("drive", 1, o_dom);
    u_ctrl.drive(1'b1, 1);
    clr_flags();
  endtask

  task automatic t_wake_stop();
    chip(cantmc_pkg::CANTMC_CHIP_STOP);
    set_mode(cantmc_pkg::CANTMC_WAKE);
    chk("term", cantmc_pkg::CANTMC_TERM_NONE, o_term);
    bus(1'b1, SIL + 2);
    chk("term", cantmc_pkg::CANTMC_TERM_GND, o_term);
    wake_pat();
    chk("wake", 1, o_wk);
    chk("irq_n", 0, o_irq_n);
    chk("rx", 0, o_rx);
    chk("mode", cantmc_pkg::CANTMC_WAKE, o_mode);
    chk("term", cantmc_pkg::CANTMC_TERM_2V5, o_term);
    chk("wd_req", 4'h1, n_wd[3:0]);
    chk("restart", 0, seen_rst);
    set_mode(cantmc_pkg::CANTMC_OFF);
    chk("rx", 1, o_rx);
    clr_flags();
    chk("irq_n", 1, o_irq_n);
    wake_pat();
    chk("wake", 0, o_wk);
    @(posedge i_mclk);
    wd_en <= 1'b1;
    set_mode(cantmc_pkg::CANTMC_WAKE);
    bus(1'b1, SIL + 2);
    wake_pat();
    chk("wake", 1, o_wk);
    chk("wd_req", 4'h1, n_wd[3:0]);
    clr_flags();
  endtask

  task automatic t_wake_sleep();
    chip(cantmc_pkg::CANTMC_CHIP_SLEEP);
    bus(1'b1, SIL + 2);
    wake_pat();
    chk("restart", 1, seen_rst);
    chk("irq_n", 1, o_irq_n);
    chk("rx", 0, o_rx);
    chip(cantmc_pkg::CANTMC_CHIP_NORMAL);
    set_mode(cantmc_pkg::CANTMC_OFF);
    set_mode(cantmc_pkg::CANTMC_WAKE);
    bus(1'b1, SIL + 2);
    wake_pat();
    chk("irq_n", 4'h0, o_irq_n);
    chk("mode", cantmc_pkg::CANTMC_WAKE, o_mode);
    clr_flags();
    set_mode(cantmc_pkg::CANTMC_OFF);
    chip(cantmc_pkg::CANTMC_CHIP_FAILSAFE);
    chk("mode", cantmc_pkg::CANTMC_WAKE, o_mode);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset();
    t_normal();
    t_timeout();
    t_rxonly();
    t_wake_stop();
    t_wake_sleep();
    print_verdict();
  end
endmodule
`default_nettype wire
